// ---- common/ppm_pkg.sv ----
// Shared constants and types for the peripheral pin multiplexer
package ppm_pkg;

    localparam int PIN_N = 16;
    typedef logic [PIN_N-1:0] ppm_pins_t;

    // Register byte offsets
    localparam logic [7:0] ADR_DIR  = 8'h00;
    localparam logic [7:0] ADR_OUT  = 8'h04;
    localparam logic [7:0] ADR_IN   = 8'h08;
    localparam logic [7:0] ADR_FUNC = 8'h0C;
    localparam logic [7:0] ADR_MODE = 8'h10;

    // Values after reset
    localparam ppm_pins_t DIR_RST  = 16'h0F00;
    localparam ppm_pins_t OUT_RST  = 16'h0000;
    localparam ppm_pins_t FUNC_RST = 16'hFFFF;
    localparam ppm_pins_t MODE_RST = 16'h0000;
    localparam ppm_pins_t SYNC_RST = 16'hFFFF;
    localparam logic      PER_IDLE = 1'b1;

    // Pin positions of the shared functions
    localparam int PIN_DMA1 = 0;
    localparam int PIN_DMA0 = 1;
    localparam int PIN_TMR  = 2;
    localparam int PIN_TX1  = 3;
    localparam int PIN_RX1  = 4;
    localparam int PIN_TX0  = 5;
    localparam int PIN_RX0  = 6;
    localparam int PIN_MISO = 7;
    localparam int PIN_SS   = 8;
    localparam int PIN_SCK  = 9;
    localparam int PIN_MOSI = 10;
    localparam int PIN_GNT1 = 11;
    localparam int PIN_RTS0 = 12;
    localparam int PIN_DTR0 = 13;
    localparam int PIN_DSR0 = 14;
    localparam int PIN_CTS0 = 15;

    // Cycle counts
    localparam int SYNC_CYC = 2;
    localparam int ACK_CYC  = 1;

endpackage : ppm_pkg

// ---- common/ppm_pad_if.sv ----
// Bundle between the pin multiplexer core and its pad bank
`timescale 1ns/1ps
interface ppm_pad_if;
    ppm_pkg::ppm_pins_t dir;
    ppm_pkg::ppm_pins_t gpio_out;
    ppm_pkg::ppm_pins_t per_out;
    ppm_pkg::ppm_pins_t per_sel;
    ppm_pkg::ppm_pins_t oe_block;
    ppm_pkg::ppm_pins_t pin_sync;

    modport core (
        output dir,
        output gpio_out,
        output per_out,
        output per_sel,
        output oe_block,
        input  pin_sync
    );

    modport pad (
        input  dir,
        input  gpio_out,
        input  per_out,
        input  per_sel,
        input  oe_block,
        output pin_sync
    );
endinterface : ppm_pad_if

// ---- design/ppm_pad_bank.sv ----
// Pad bank: input synchroniser and registered pin drive
`timescale 1ns/1ps
module ppm_pad_bank (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Core side
    ppm_pad_if.pad                padi,
    // Pins
    input  wire ppm_pkg::ppm_pins_t pio_in,
    output ppm_pkg::ppm_pins_t      pio_out,
    output ppm_pkg::ppm_pins_t      pio_oe
);
    import ppm_pkg::*;

    ppm_pins_t meta;

    // Two-flop synchroniser
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta          <= SYNC_RST;
            padi.pin_sync <= SYNC_RST;
        end else begin
            meta          <= pio_in;
            padi.pin_sync <= meta;
        end
    end

    // Output value: peripheral or general purpose
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pio_out <= OUT_RST;
        end else begin
            pio_out <= (padi.per_sel & padi.per_out) | (~padi.per_sel & padi.gpio_out);
        end
    end

    // Output enable per pin
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pio_oe <= DIR_RST;
        end else begin
            pio_oe <= padi.dir & ~padi.oe_block;
        end
    end

    sync_lat_a: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst, 2) |-> padi.pin_sync == $past(pio_in, 2))
        else $error("pin input not seen two cycles later");

    gate_oe_a: assert property (@(posedge ref_clk) disable iff (rst)
        padi.oe_block[PIN_TMR] |=> !pio_oe[PIN_TMR])
        else $error("timer pin driven in gate mode");

    wrap_out_a: assert property (@(posedge ref_clk) disable iff (rst)
        padi.per_sel[PIN_TMR] ##1 padi.per_sel[PIN_TMR]
        |-> pio_out[PIN_TMR] == $past(padi.per_out[PIN_TMR]))
        else $error("timer wrap level not on pin");
endmodule : ppm_pad_bank

// ---- design/ppm_pin_mux.sv ----
// Peripheral pin multiplexer with classic Wishbone register slave
`timescale 1ns/1ps
module ppm_pin_mux (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // Programmable pins
    input  wire ppm_pkg::ppm_pins_t pio_in,
    output ppm_pkg::ppm_pins_t      pio_out,
    output ppm_pkg::ppm_pins_t      pio_oe,
    // DMA engine
    output logic      [1:0]         dma_ready_n,
    output logic      [1:0]         dma_done_n,
    // Timer
    input  wire logic               timer_wrap_out_n,
    output logic                    timer_gate_n,
    // UART channels
    input  wire logic [1:0]         uart_tx,
    output logic      [1:0]         uart_rx,
    output logic                    uart_cts_n,
    output logic                    uart_dsr_n,
    input  wire logic               uart_dtr_n,
    input  wire logic               uart_rts_n,
    // Serial port
    input  wire logic               spi_mosi,
    input  wire logic               spi_sck,
    input  wire logic               spi_ss_n,
    output logic                    spi_miso,
    // PCI grant line 1
    input  wire logic               pci_gnt1_n
);
    import ppm_pkg::*;

    typedef enum logic [1:0] {
        WB_IDLE = 2'b01,
        WB_ACK  = 2'b10
    } ppm_wb_e;

    ppm_wb_e     state;
    ppm_wb_e     next_state;
    logic        req;
    logic        wr_en;
    ppm_pins_t   dir;
    ppm_pins_t   gpio_out;
    ppm_pins_t   func;
    ppm_pins_t   mode;
    ppm_pins_t   per_out;
    ppm_pins_t   oe_block;
    logic [31:0] next_dat;

    ppm_pad_if padc ();

    // Byte-lane merge of a 16-bit register
    function automatic ppm_pins_t merge16(
        input ppm_pins_t   old,
        input logic [31:0] d,
        input logic [3:0]  s
    );
        ppm_pins_t r;
        r       = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge16

    // Write strobe for one register offset
    function automatic logic wr_at(
        input logic       en,
        input logic [7:0] adr,
        input logic [7:0] target
    );
        return en && (adr == target);
    endfunction : wr_at

    // Bus request and write strobe
    assign req      = wb_cyc_i && wb_stb_i;
    assign wr_en    = req && wb_we_i && (state == WB_ACK);
    assign wb_ack_o = (state == WB_ACK);

    // Bus state
    always_comb begin
        next_state = state;
        case (state)
            WB_IDLE: begin
                if (req) begin
                    next_state = WB_ACK;
                end
            end
            WB_ACK: begin
                next_state = WB_IDLE;
            end
            default: begin
                next_state = WB_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= WB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Read data mux, unmapped reads zero
    always_comb begin
        next_dat = 32'h0000_0000;
        case (wb_adr_i)
            ADR_DIR: begin
                next_dat[15:0] = dir;
            end
            ADR_OUT: begin
                next_dat[15:0] = gpio_out;
            end
            ADR_IN: begin
                next_dat[15:0] = padc.pin_sync;
            end
            ADR_FUNC: begin
                next_dat[15:0] = func;
            end
            ADR_MODE: begin
                next_dat[15:0] = mode;
            end
            default: begin
                next_dat = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (state == WB_IDLE && req && !wb_we_i) begin
            wb_dat_o <= next_dat;
        end
    end

    // Direction register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dir <= DIR_RST;
        end else if (wr_at(wr_en, wb_adr_i, ADR_DIR)) begin
            dir <= merge16(dir, wb_dat_i, wb_sel_i);
        end
    end

    // General purpose output data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gpio_out <= OUT_RST;
        end else if (wr_at(wr_en, wb_adr_i, ADR_OUT)) begin
            gpio_out <= merge16(gpio_out, wb_dat_i, wb_sel_i);
        end
    end

    // Function select, one means peripheral
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            func <= FUNC_RST;
        end else if (wr_at(wr_en, wb_adr_i, ADR_FUNC)) begin
            func <= merge16(func, wb_dat_i, wb_sel_i);
        end
    end

    // Alternate select, one means second function
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode <= MODE_RST;
        end else if (wr_at(wr_en, wb_adr_i, ADR_MODE)) begin
            mode <= merge16(mode, wb_dat_i, wb_sel_i);
        end
    end

    // Peripheral values toward the pins
    always_comb begin
        per_out           = {PIN_N{PER_IDLE}};
        per_out[PIN_TMR]  = timer_wrap_out_n;
        per_out[PIN_TX1]  = uart_tx[1];
        per_out[PIN_TX0]  = uart_tx[0];
        per_out[PIN_SS]   = spi_ss_n;
        per_out[PIN_SCK]  = spi_sck;
        per_out[PIN_MOSI] = spi_mosi;
        per_out[PIN_GNT1] = pci_gnt1_n;
        per_out[PIN_RTS0] = uart_rts_n;
        per_out[PIN_DTR0] = uart_dtr_n;
    end

    // Gate mode never drives the timer pin
    always_comb begin
        oe_block          = '0;
        oe_block[PIN_TMR] = func[PIN_TMR] && mode[PIN_TMR];
    end

    assign padc.dir      = dir;
    assign padc.gpio_out = gpio_out;
    assign padc.per_out  = per_out;
    assign padc.per_sel  = func & ~oe_block;
    assign padc.oe_block = oe_block;

    ppm_pad_bank u_pad (
        .ref_clk (ref_clk),
        .rst     (rst),
        .padi    (padc.pad),
        .pio_in  (pio_in),
        .pio_out (pio_out),
        .pio_oe  (pio_oe)
    );

    // DMA request and done inputs, idle high when unselected
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dma_ready_n <= {2{PER_IDLE}};
            dma_done_n  <= {2{PER_IDLE}};
        end else begin
            dma_ready_n[0] <= (func[PIN_DMA0] && !mode[PIN_DMA0])
                              ? padc.pin_sync[PIN_DMA0] : PER_IDLE;
            dma_done_n[0]  <= (func[PIN_DMA0] && mode[PIN_DMA0])
                              ? padc.pin_sync[PIN_DMA0] : PER_IDLE;
            dma_ready_n[1] <= (func[PIN_DMA1] && !mode[PIN_DMA1])
                              ? padc.pin_sync[PIN_DMA1] : PER_IDLE;
            dma_done_n[1]  <= (func[PIN_DMA1] && mode[PIN_DMA1])
                              ? padc.pin_sync[PIN_DMA1] : PER_IDLE;
        end
    end

    // Timer gate input
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer_gate_n <= PER_IDLE;
        end else begin
            timer_gate_n <= oe_block[PIN_TMR]
                            ? padc.pin_sync[PIN_TMR] : PER_IDLE;
        end
    end

    // UART receive and modem inputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            uart_rx    <= {2{PER_IDLE}};
            uart_cts_n <= PER_IDLE;
            uart_dsr_n <= PER_IDLE;
        end else begin
            uart_rx[0] <= func[PIN_RX0] ? padc.pin_sync[PIN_RX0] : PER_IDLE;
            uart_rx[1] <= func[PIN_RX1] ? padc.pin_sync[PIN_RX1] : PER_IDLE;
            uart_cts_n <= func[PIN_CTS0] ? padc.pin_sync[PIN_CTS0] : PER_IDLE;
            uart_dsr_n <= func[PIN_DSR0] ? padc.pin_sync[PIN_DSR0] : PER_IDLE;
        end
    end

    // Serial data-in
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            spi_miso <= PER_IDLE;
        end else begin
            spi_miso <= func[PIN_MISO] ? padc.pin_sync[PIN_MISO] : PER_IDLE;
        end
    end

    ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle answer");

    dir_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_en && wb_adr_i == ADR_DIR && wb_sel_i[1:0] == 2'b11)
        |=> dir == $past(wb_dat_i[15:0]))
        else $error("direction write lost");

    reset_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> dir == 16'h0F00 && func == 16'hFFFF)
        else $error("reset direction wrong");

    tx_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> !pio_oe[PIN_TX0] && !pio_oe[PIN_TX1])
        else $error("transmit pin driven after reset");

    ready_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        (func[PIN_DMA0] && !mode[PIN_DMA0])
        |=> dma_ready_n[0] == $past(padc.pin_sync[PIN_DMA0]) && dma_done_n[0])
        else $error("channel 0 ready not routed");

    done_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        (func[PIN_DMA1] && mode[PIN_DMA1])
        |=> dma_done_n[1] == $past(padc.pin_sync[PIN_DMA1]) && dma_ready_n[1])
        else $error("channel 1 done not routed");

    gate_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        (func[PIN_TMR] && mode[PIN_TMR])
        |=> timer_gate_n == $past(padc.pin_sync[PIN_TMR]))
        else $error("timer gate not routed");

    rx_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        func[PIN_RX0] ##1 (func[PIN_RX0] && !$past(rst, 2) && !$past(rst, 3))
        |-> uart_rx[0] == $past(pio_in[PIN_RX0], 3))
        else $error("receive 0 not routed");

    modem_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        func[PIN_CTS0] |=> uart_cts_n == $past(padc.pin_sync[PIN_CTS0]))
        else $error("clear-to-send not routed");

    read_in_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wb_ack_o && !wb_we_i && wb_adr_i == ADR_IN)
        |-> wb_dat_o == {16'h0000, $past(padc.pin_sync)})
        else $error("input register read wrong");
endmodule : ppm_pin_mux

// ---- dv/ppm_board.sv ----
// Board model: resolves each pin from block drive and external drivers
`timescale 1ns/1ps
module ppm_board
    import ppm_pkg::*;
(
    // Block side
    input  wire ppm_pkg::ppm_pins_t pio_out,
    input  wire ppm_pkg::ppm_pins_t pio_oe,
    // External agents
    input  wire ppm_pkg::ppm_pins_t ext_drive,
    // Resolved pin levels
    output ppm_pkg::ppm_pins_t      pio_in
);
    // Block wins where it drives, else the agent sets the level
    assign pio_in = (pio_oe & pio_out) | (~pio_oe & ext_drive);
endmodule : ppm_board

// ---- dv/peripheral_pin_mux_tb_top.sv ----
// Self-checking bench for the peripheral pin multiplexer
`timescale 1ns/1ps
module peripheral_pin_mux_tb_top;
    import ppm_pkg::*;
    logic ref_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack_o, tmr_n, gate_n, miso;
    logic cts_n, dsr_n, dtr_n, rts_n, mosi, sck, ss_n, gnt_n;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rd;
    logic [1:0]  rdy_n, done_n, utx, urx;
    ppm_pins_t   pin, pout, poe, ext, p, d;
    int          err_total, n_compared;

    ppm_pin_mux u_ppm_pin_mux (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pio_in(pin),
        .pio_out(pout), .pio_oe(poe), .dma_ready_n(rdy_n), .dma_done_n(done_n),
        .timer_wrap_out_n(tmr_n), .timer_gate_n(gate_n), .uart_tx(utx), .uart_rx(urx),
        .uart_cts_n(cts_n), .uart_dsr_n(dsr_n), .uart_dtr_n(dtr_n), .uart_rts_n(rts_n),
        .spi_mosi(mosi), .spi_sck(sck), .spi_ss_n(ss_n), .spi_miso(miso),
        .pci_gnt1_n(gnt_n));
    ppm_board u_ppm_board (.pio_out(pout), .pio_oe(poe), .ext_drive(ext), .pio_in(pin));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= dat;
        wb_sel <= 4'hF;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
        end
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb_cycle

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        complete_run();
    end

    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
        {tmr_n, dtr_n, rts_n, mosi, sck, ss_n, gnt_n} = 7'h7F;
        utx = 2'h3;
        ext = 16'hFFFF;
        err_total = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        settle(2);
        // Reset directions and idle peripheral lines
        check("oe_rst", poe, 16'h0F00);
        check("tx_oe_rst", 16'({poe[PIN_TX0], poe[PIN_TX1]}), 16'h0);
        check("idle", 16'({rdy_n, done_n, gate_n, urx, miso}), 16'h00FF);
        // Register reset values and an unmapped slot
        wb_cycle(1'b0, ADR_DIR, 32'h0);
        check("dir_rst", rd[15:0], 16'h0F00);
        wb_cycle(1'b0, ADR_FUNC, 32'h0);
        check("func_rst", rd[15:0], 16'hFFFF);
        wb_cycle(1'b0, 8'h14, 32'h0);
        check("unmapped", rd[15:0], 16'h0000);
        for (int k = 0; k < 2; k++) begin
            p = k ? 16'hA5C1 : 16'h5A3E;
            d = k ? 16'hFF00 : 16'h00FF;
            // General-purpose mode
            wb_cycle(1'b1, ADR_FUNC, 32'h0);
            wb_cycle(1'b1, ADR_DIR, {16'h0, d});
            wb_cycle(1'b1, ADR_OUT, {16'h0, p});
            @(posedge ref_clk);
            ext <= ~p;
            settle(4);
            check("gp_oe", poe, d);
            check("gp_out", pout & d, p & d);
            wb_cycle(1'b0, ADR_IN, 32'h0);
            check("gp_in", rd[15:0], (d & p) | (~d & ~p));
            // Peripheral mode, first or second alternate
            wb_cycle(1'b1, ADR_FUNC, 32'h0000FFFF);
            wb_cycle(1'b1, ADR_MODE, k ? 32'h7 : 32'h0);
            wb_cycle(1'b1, ADR_DIR, 32'h3F2C);
            @(posedge ref_clk);
            utx   <= p[1:0];
            tmr_n <= ~p[2];
            {dtr_n, rts_n, gnt_n, sck, ss_n, mosi} <= p[8:3];
            ext   <= p;
            settle(5);
            check("tx0", 16'(pout[PIN_TX0]), 16'(p[0]));
            check("tx1", 16'(pout[PIN_TX1]), 16'(p[1]));
            check("mosi", 16'(pout[PIN_MOSI]), 16'(p[3]));
            check("sck_ss", 16'({pout[PIN_SCK], pout[PIN_SS]}), 16'(p[5:4]));
            check("gnt1", 16'(pout[PIN_GNT1]), 16'(p[6]));
            check("dtr_rts", 16'({pout[PIN_DTR0], pout[PIN_RTS0]}), 16'(p[8:7]));
            check("rx", 16'(urx), 16'({p[PIN_RX1], p[PIN_RX0]}));
            check("rx_own", 16'(urx[0] ^ urx[1]), 16'(p[4] ^ p[6]));
            check("miso", 16'(miso), 16'(p[PIN_MISO]));
            check("cts_dsr", 16'({cts_n, dsr_n}), 16'(p[15:14]));
            if (k == 0) begin
                check("wrap", 16'({poe[PIN_TMR], pout[PIN_TMR]}), 16'({1'b1, ~p[2]}));
                check("ready", 16'(rdy_n), 16'({p[PIN_DMA1], p[PIN_DMA0]}));
                check("done_idle", 16'(done_n), 16'h3);
            end else begin
                check("gate", 16'({poe[PIN_TMR], gate_n}), 16'({1'b0, p[2]}));
                check("done", 16'(done_n), 16'({p[PIN_DMA1], p[PIN_DMA0]}));
                check("rdy_idle", 16'(rdy_n), 16'h3);
            end
        end
        complete_run();
    end
endmodule : peripheral_pin_mux_tb_top
